// ---- verilog/acsc_ctrl.sv ----
// converter channel and sequence control with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
module acsc_ctrl (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rstn,
  // ahb-lite slave
  input  wire logic                i_hsel,
  input  wire logic [31:0]         i_haddr,
  input  wire logic [1:0]          i_htrans,
  input  wire logic                i_hwrite,
  input  wire logic [2:0]          i_hsize,
  input  wire logic [31:0]         i_hwdata,
  input  wire logic                i_hready,
  output logic      [31:0]         o_hrdata,
  output logic                     o_hreadyout,
  output logic                     o_hresp,
  // converter
  input  wire logic [9:0]          i_adc_data,
  output acsc_pkg::acsc_conv_s     o_conv,
  // port pin analog forcing
  output logic      [7:0]          o_port4_analog,
  output logic      [3:0]          o_port5_analog,
  // interrupt
  output logic                     o_irq
);

  // ******************************
  // state
  // ******************************
  typedef struct packed {
    acsc_pkg::acsc_state_e fsm;
    logic [9:0]            cnt;
    logic [7:0]            p4;
    logic [3:0]            p5;
    logic [3:0]            chsel;
    logic                  chen;
    logic                  aden;
    logic                  start;
    logic                  done;
    logic [1:0]            cks;
    logic                  res;
    logic [9:0]            result;
    logic                  irq_st;
    logic                  irq_mk;
    logic                  irq;
    logic                  conn;
    logic                  pend;
    logic                  pwrite;
    logic                  pmap;
    logic [7:0]            pidx;
    logic [31:0]           hrdata;
    logic                  hready;
  } acsc_regs_s;

  acsc_regs_s st_reg;
  acsc_regs_s st_next;

  // total cpu cycles of one conversion, less one
  function automatic logic [9:0] conv_len(input logic [1:0] cks, input logic res);
    logic [9:0] div;
    logic [9:0] per;
    div = 10'h001;
    case (cks)
      acsc_pkg::CKS_DIV16: div = 10'h010;
      acsc_pkg::CKS_DIV8:  div = 10'h008;
      acsc_pkg::CKS_DIV1:  div = 10'h001;
      default:             div = 10'h002;
    endcase
    per = res ? acsc_pkg::PERIODS_10B : acsc_pkg::PERIODS_8B;
    conv_len = 10'(div * acsc_pkg::PRESCALE * per - 10'h001);
  endfunction : conv_len

  // ******************************
  // next state
  // ******************************
  logic       addr_ok;
  logic       wr;
  logic [7:0] wd;
  logic       fin;

  always_comb begin
    st_next = st_reg;
    addr_ok = i_hsel && i_htrans[1] && i_hready;
    wr      = st_reg.pend && st_reg.pwrite && st_reg.pmap;
    wd      = i_hwdata[7:0];
    fin     = (st_reg.fsm == acsc_pkg::ST_CONV) && (st_reg.cnt == 10'h000);

    // converter sequence
    if (st_reg.fsm == acsc_pkg::ST_CONV) begin
      st_next.cnt = st_reg.cnt - 10'h001;
      if (fin) begin
        st_next.fsm   = acsc_pkg::ST_IDLE;
        st_next.start = 1'b0;
        st_next.done  = 1'b1;
        st_next.irq_st = 1'b1;
        // eight-bit mode keeps only the top eight bits
        st_next.result = st_reg.res ? i_adc_data : {i_adc_data[9:2], 2'h0};
      end
    end

    // bus data phase: one wait state, then answer
    st_next.hready = 1'b1;
    st_next.pend   = 1'b0;
    if (st_reg.pend) begin
      st_next.hrdata = 32'h0000_0000;
      if (st_reg.pmap && !st_reg.pwrite) begin
        if (st_reg.pidx == acsc_pkg::IDX_CTRL) begin
          st_next.hrdata[7:0] = {st_reg.aden, st_reg.start, st_reg.done, st_reg.chen, st_reg.chsel};
        end else if (st_reg.pidx == acsc_pkg::IDX_P4) begin
          st_next.hrdata[7:0] = st_reg.p4;
        end else if (st_reg.pidx == acsc_pkg::IDX_P5) begin
          st_next.hrdata[3:0] = st_reg.p5;
        end else if (st_reg.pidx == acsc_pkg::IDX_RES_HI) begin
          st_next.hrdata[7:0] = st_reg.result[9:2];
        end else if (st_reg.pidx == acsc_pkg::IDX_RES_LO) begin
          st_next.hrdata[acsc_pkg::LO_CKS1] = st_reg.cks[1];
          st_next.hrdata[acsc_pkg::LO_RES]  = st_reg.res;
          st_next.hrdata[acsc_pkg::LO_CKS0] = st_reg.cks[0];
          st_next.hrdata[1:0]               = st_reg.result[1:0];
        end else if (st_reg.pidx == acsc_pkg::IDX_IRQ_ST) begin
          st_next.hrdata[0] = st_reg.irq_st;
          // read clears, but an end of conversion in this cycle wins
          st_next.irq_st = fin;
        end else if (st_reg.pidx == acsc_pkg::IDX_IRQ_MK) begin
          st_next.hrdata[0] = st_reg.irq_mk;
        end
      end
    end

    // register writes
    if (wr) begin
      if (st_reg.pidx == acsc_pkg::IDX_CTRL) begin
        st_next.chsel = wd[3:0];
        st_next.chen  = wd[acsc_pkg::CTRL_CHEN];
        st_next.aden  = wd[acsc_pkg::CTRL_EN];
        if (!wd[acsc_pkg::CTRL_EN] || !wd[acsc_pkg::CTRL_START]) begin
          // dropping start or enable aborts a conversion in flight
          st_next.fsm   = acsc_pkg::ST_IDLE;
          st_next.start = 1'b0;
          st_next.cnt   = 10'h000;
          if (!fin) begin
            st_next.done = st_reg.done;
          end
        end else if (st_reg.aden || wd[acsc_pkg::CTRL_EN]) begin
          // start with enable set: done drops and a run begins
          st_next.fsm   = acsc_pkg::ST_CONV;
          st_next.start = 1'b1;
          st_next.done  = 1'b0;
          st_next.cnt   = conv_len(st_reg.cks, st_reg.res);
        end
      end else if (st_reg.pidx == acsc_pkg::IDX_P4) begin
        st_next.p4 = wd;
      end else if (st_reg.pidx == acsc_pkg::IDX_P5) begin
        st_next.p5 = wd[acsc_pkg::P5_BITS-1:0];
      end else if (st_reg.pidx == acsc_pkg::IDX_RES_LO) begin
        st_next.cks = {wd[acsc_pkg::LO_CKS1], wd[acsc_pkg::LO_CKS0]};
        st_next.res = wd[acsc_pkg::LO_RES];
      end else if (st_reg.pidx == acsc_pkg::IDX_IRQ_MK) begin
        st_next.irq_mk = wd[0];
      end
    end
    // start with enable clear is dropped: no run, done untouched
    if (wr && st_reg.pidx == acsc_pkg::IDX_CTRL && wd[acsc_pkg::CTRL_START] && !wd[acsc_pkg::CTRL_EN]) begin
      st_next.done = st_reg.done;
    end

    // address phase capture
    if (addr_ok) begin
      st_next.pend   = 1'b1;
      st_next.hready = 1'b0;
      st_next.pwrite = i_hwrite;
      st_next.pidx   = i_haddr[9:2];
      st_next.pmap   = (i_haddr[31:10] == 22'h000000) && (i_haddr[1:0] == 2'h0);
    end

    st_next.irq = st_next.irq_st && st_next.irq_mk;
    // registered so the path switch never glitches on a control write
    st_next.conn = st_next.chen && st_next.aden;
  end

  // ******************************
  // registers
  // ******************************
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_reg        <= '0;
      st_reg.fsm    <= acsc_pkg::ST_IDLE;
      st_reg.p4     <= acsc_pkg::P4_RST;
      st_reg.p5     <= acsc_pkg::P5_RST;
      st_reg.hready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ******************************
  // outputs
  // ******************************
  assign o_hrdata          = st_reg.hrdata;
  assign o_hreadyout       = st_reg.hready;
  assign o_hresp           = 1'b0;
  assign o_irq             = st_reg.irq;
  assign o_port4_analog    = st_reg.p4;
  assign o_port5_analog    = st_reg.p5;
  assign o_conv.enable     = st_reg.aden;
  assign o_conv.connect    = st_reg.conn;
  assign o_conv.chan       = st_reg.chsel;
  assign o_conv.ten_bit    = st_reg.res;
  assign o_conv.sampling   = (st_reg.fsm == acsc_pkg::ST_CONV);

endmodule : acsc_ctrl
`default_nettype wire

// ---- verilog/acsc_pkg.sv ----
// constants and types of the converter channel and sequence control block
package acsc_pkg;

  // ******************************
  // register indices, byte address = index * 4
  // ******************************
  localparam logic [7:0] IDX_CTRL   = 8'hc8;
  localparam logic [7:0] IDX_P4     = 8'hc6;
  localparam logic [7:0] IDX_P5     = 8'hc7;
  localparam logic [7:0] IDX_RES_HI = 8'hc9;
  localparam logic [7:0] IDX_RES_LO = 8'hca;
  localparam logic [7:0] IDX_IRQ_ST = 8'hcb;
  localparam logic [7:0] IDX_IRQ_MK = 8'hcc;

  // ******************************
  // field positions
  // ******************************
  localparam int CTRL_CHEN  = 4;
  localparam int CTRL_DONE  = 5;
  localparam int CTRL_START = 6;
  localparam int CTRL_EN    = 7;
  localparam int LO_CKS0    = 4;
  localparam int LO_RES     = 5;
  localparam int LO_CKS1    = 6;
  localparam int P5_BITS    = 4;

  // ******************************
  // reset values and timing
  // ******************************
  localparam logic [7:0] P4_RST      = 8'h00;
  localparam logic [3:0] P5_RST      = 4'h0;
  localparam logic [1:0] CKS_DIV16   = 2'h0;
  localparam logic [1:0] CKS_DIV8    = 2'h1;
  localparam logic [1:0] CKS_DIV1    = 2'h2;
  localparam logic [1:0] CKS_DIV2    = 2'h3;
  localparam logic [9:0] PRESCALE    = 10'h004;
  localparam logic [9:0] PERIODS_10B = 10'h00e;
  localparam logic [9:0] PERIODS_8B  = 10'h00c;

  typedef enum logic {ST_IDLE, ST_CONV} acsc_state_e;

  // converter-side controls
  typedef struct packed {
    logic       enable;
    logic       connect;
    logic [3:0] chan;
    logic       ten_bit;
    logic       sampling;
  } acsc_conv_s;

endpackage : acsc_pkg

// ---- verif/acsc_ctrl_sva.sv ----
// assertion checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acsc_ctrl_sva (
  // watched ports
  input wire logic                 i_clk,
  input wire logic                 i_rstn,
  input wire logic                 i_hsel,
  input wire logic [1:0]           i_htrans,
  input wire logic                 i_hready,
  input wire logic                 o_hreadyout,
  input wire acsc_pkg::acsc_conv_s o_conv,
  input wire logic [7:0]           o_port4_analog
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ******************************
  // bus and converter relations
  // ******************************
  property p_take; i_hsel && i_htrans[1] && i_hready |=> !o_hreadyout; endproperty
  a_take: assert property (p_take) else $error("no wait state");
  property p_one; !o_hreadyout |=> o_hreadyout; endproperty
  a_one: assert property (p_one) else $error("wait state too long");
  property p_rst; $rose(i_rstn) |-> o_hreadyout && !o_conv.sampling && o_port4_analog == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_samp; o_conv.sampling |-> o_conv.enable; endproperty
  a_samp: assert property (p_samp) else $error("converting while off");
  property p_go; $rose(o_conv.sampling) |-> !$past(o_hreadyout); endproperty
  a_go: assert property (p_go) else $error("start without write");
  property p_hold; $rose(o_conv.sampling) |=> o_conv.sampling; endproperty
  a_hold: assert property (p_hold) else $error("conversion too short");
  property p_p4; $changed(o_port4_analog) |-> !$past(o_hreadyout); endproperty
  a_p4: assert property (p_p4) else $error("port4 moved alone");
  property p_chan; $changed(o_conv.chan) |-> !$past(o_hreadyout); endproperty
  a_chan: assert property (p_chan) else $error("channel moved alone");
endmodule : acsc_ctrl_sva
bind acsc_ctrl acsc_ctrl_sva u_sva (.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_htrans(i_htrans),
  .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_conv(o_conv), .o_port4_analog(o_port4_analog));
`default_nettype wire

// ---- verif/acsc_ctrl_tb.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acsc_ctrl_tb;
  logic                 i_clk = 1'b0;
  logic                 i_rstn = 1'b0;
  logic [1:0]           htrans = 2'h0;
  logic [31:0]          haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic                 hwrite = 1'b0, hready, hresp, irq, rd_ph = 1'b0;
  logic [9:0]           adc = 10'h0;
  acsc_pkg::acsc_conv_s conv;
  logic [7:0]           p4;
  logic [3:0]           p5;
  logic [31:0]          expq[$];
  int                   miscompares = 0, checks = 0, seed = 32'h8d45b844, k, n;
  always #2.5 i_clk = ~i_clk;
  acsc_ctrl dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_adc_data(adc), .o_conv(conv), .o_port4_analog(p4),
    .o_port5_analog(p5), .o_irq(irq));
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (e !== g) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // reads note the expected word; the monitor compares it
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge i_clk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    if (!w) expq.push_back(d);
    do @(posedge i_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk); while (hready !== 1'b1);
  endtask : bus
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  always @(posedge i_clk) begin
    if (rd_ph && hready === 1'b1) chk("hrdata", expq.pop_front(), hrdata);
    if (hready === 1'b1) rd_ph <= htrans[1] && !hwrite;
  end
  initial begin
    #400000;
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    bus(0, 32'h318, 0);
    bus(0, 32'h31c, 0);
    n = $random(seed);
    bus(1, 32'h318, 32'h1 << n[2:0]);
    bus(1, 32'h31c, 32'hffff_fff0);
    bus(0, 32'h318, 32'h1 << n[2:0]);
    bus(0, 32'h31c, 0);
    chk("port4", 32'h1 << n[2:0], 32'(p4));
    chk("port5", 0, 32'(p5));
    bus(1, 32'h400, n);
    bus(0, 32'h400, 0);
    $display("test registers done");
    bus(1, 32'h320, 32'h080);
    repeat (20000) @(posedge i_clk);
    // every clock select in both resolutions, mask alternating
    for (int i = 0; i < 8; i++) begin
      adc <= 10'($random(seed));
      bus(1, 32'h328, {25'h0, i[1], i[2], i[0], 4'h0});
      bus(1, 32'h330, 32'(i[0]));
      bus(1, 32'h320, 32'h0d0 | i);
      chk("chan", i, 32'(conv.chan));
      chk("connect", 1, 32'(conv.connect));
      chk("ten_bit", i[2], 32'(conv.ten_bit));
      chk("enable", 1, 32'(conv.enable));
      k = 0;
      do begin @(posedge i_clk); #1; k++; end while (conv.sampling !== 1'b0 && k < 2000);
      n = (i[1:0] == 0 ? 16 : i[1:0] == 1 ? 8 : i[1:0] == 2 ? 1 : 2) * 4 * (i[2] ? 14 : 12);
      chk("cycles", n - 1, k);
      chk("irq", i[0], 32'(irq));
      bus(0, 32'h32c, 1);
      @(posedge i_clk); #1;
      chk("irq_clr", 0, 32'(irq));
      bus(0, 32'h320, 32'h0b0 | i);
      bus(0, 32'h324, 32'(adc[9:2]));
      bus(0, 32'h328, {25'h0, i[1], i[2], i[0], 2'h0, i[2] ? adc[1:0] : 2'h0});
      $display("test conversion %0d done", i);
    end
    bus(1, 32'h320, 32'h040);
    @(posedge i_clk); #1;
    chk("idle", 0, 32'({conv.sampling, irq}));
    bus(0, 32'h320, 32'h020);
    bus(1, 32'h328, 0);
    bus(1, 32'h320, 32'h080);
    repeat (20000) @(posedge i_clk);
    bus(1, 32'h320, 32'h0d3);
    bus(0, 32'h320, 32'h0d3);
    bus(1, 32'h320, 0);
    repeat (800) @(posedge i_clk);
    chk("abort", 0, 32'({conv.sampling, conv.connect, irq}));
    bus(0, 32'h320, 0);
    bus(0, 32'h32c, 0);
    $display("test abort done");
    complete_run();
  end
endmodule : acsc_ctrl_tb
`default_nettype wire
